// *** testbench.sv ***
// self-checking testbench for the responder
`timescale 1ns/1ps
module testbench;
  import wssr_pkg::*;
  logic        clk_in, rst_in, data_wr_in, data_rd_in, error_in;
  logic        fhs_capable_in, request_true_out, cmd_valid_out, ok;
  logic [15:0] data_in, response_out, data_out, cmd_out, rd_word;
  int          fails, num_checks, seen;
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  wssr_top DUT (.clk_in(clk_in), .rst_in(rst_in), .data_wr_in(data_wr_in),
    .data_in(data_in), .data_rd_in(data_rd_in), .error_in(error_in),
    .fhs_capable_in(fhs_capable_in), .response_out(response_out),
    .data_out(data_out), .request_true_out(request_true_out),
    .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out));
  wssr_cmdr_model cmdr (.clk_in(clk_in), .response_in(response_out),
    .rd_data_in(data_out), .data_wr_out(data_wr_in),
    .data_rd_out(data_rd_in), .data_out(data_in));
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic guard;
    if (!ok)
    begin
      fails++;
      report_and_stop;
    end
  endtask
  task automatic cmd(logic [15:0] w);
    cmdr.send(w, ok);
    guard;
    @(negedge clk_in);
    chk("cmd valid", 16'h0001, {15'h0000, cmd_valid_out});
    chk("cmd word", w, cmd_out);
    repeat (5) @(negedge clk_in);
  endtask
  task automatic drive_err(logic v);
    @(posedge clk_in);
    error_in <= v;
  endtask
  task automatic query(logic [15:0] w);
    cmdr.send(w, ok);
    guard;
    cmdr.fetch(rd_word, ok);
    guard;
    repeat (3) @(negedge clk_in);
    chk("read ready", 16'h0000, {15'h0000, response_out[10]});
  endtask
  task automatic watch_irq;
    seen = 0;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk_in);
      seen += int'(request_true_out === 1'b1);
    end
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("response", 16'h7bff, response_out);
    chk("idle data", 16'hffff, data_out);
  endtask
  task automatic t_replies;
    query({CMD_READ_PROTOCOL, 8'hff});
    chk("protocol", 16'hfe6b, rd_word);
    query({CMD_BYTE_REQUEST, 8'h00});
    chk("byte request", 16'hffff, rd_word);
    query({CMD_CTRL_RESPONSE, 8'h00});
    chk("control response", 16'hffff, rd_word);
    query({CMD_ASYNC_MODE, 8'h0c});
    chk("async both", 16'hfffc, rd_word);
    query({CMD_ASYNC_MODE, 8'h08});
    chk("async resp", 16'hfff8, rd_word);
    query({CMD_ASYNC_MODE, 8'h01});
    chk("async fail", 16'h0007, {12'h000, rd_word[15:12]});
    query({CMD_ASYNC_MODE, 8'h02});
    chk("async fail", 16'h0007, {12'h000, rd_word[15:12]});
  endtask
  task automatic t_lock;
    cmd({CMD_SET_LOCK, 8'h00});
    chk("locked", 16'h0000, {15'h0000, response_out[7]});
    cmd({CMD_CLEAR_LOCK, 8'h00});
    chk("unlocked", 16'h0001, {15'h0000, response_out[7]});
    cmd(16'h1200);
    chk("no reply", 16'h0200, response_out & 16'h0600);
  endtask
  task automatic t_irq;
    drive_err(1'b1);
    watch_irq;
    chk("event while off", 16'h0000, 16'(seen));
    query({CMD_STATUS_QUERY, 8'h00});
    chk("status clean", 16'hff00, rd_word);
    drive_err(1'b0);
    cmd({CMD_IRQ_ENABLE, 8'h01});
    drive_err(1'b1);
    watch_irq;
    chk("event count", 16'h0001, 16'(seen));
    drive_err(1'b0);
    query({CMD_STATUS_QUERY, 8'h00});
    chk("status flagged", 16'hff40, rd_word);
    query({CMD_STATUS_QUERY, 8'h00});
    chk("status cleared", 16'hff00, rd_word);
    cmd({CMD_IRQ_ENABLE, 8'h00});
    drive_err(1'b1);
    watch_irq;
    chk("event after off", 16'h0000, 16'(seen));
    drive_err(1'b0);
  endtask
  task automatic t_fhs;
    @(posedge clk_in);
    fhs_capable_in <= 1'b1;
    repeat (8) @(negedge clk_in);
    chk("fhs on", 16'h0000, {15'h0000, response_out[8]});
    @(posedge clk_in);
    fhs_capable_in <= 1'b0;
    repeat (8) @(negedge clk_in);
    chk("fhs off", 16'h0001, {15'h0000, response_out[8]});
  endtask
  task automatic t_mid_reset;
    cmd({CMD_SET_LOCK, 8'h00});
    cmd({CMD_READ_PROTOCOL, 8'hff});
    chk("reply pending", 16'h0400, response_out & 16'h0400);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    chk("response after reset", 16'h7bff, response_out);
    chk("data after reset", 16'hffff, data_out);
  endtask
  initial
  begin
    rst_in = 1'b1;
    error_in = 1'b0;
    fhs_capable_in = 1'b0;
    fails = 0;
    num_checks = 0;
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (4) @(negedge clk_in);
    t_reset;
    t_replies;
    t_lock;
    t_irq;
    t_mid_reset;
    t_fhs;
    report_and_stop;
  end
endmodule

// *** wssr_asserts.sv ***
// assertions on the responder's ports
`timescale 1ns/1ps
module wssr_asserts
  import wssr_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        data_wr_in,
  input wire logic [15:0] data_in,
  input wire logic        data_rd_in,
  input wire logic        error_in,
  input wire logic        fhs_capable_in,
  input wire logic [15:0] response_out,
  input wire logic [15:0] data_out,
  input wire logic        request_true_out,
  input wire logic [15:0] cmd_out,
  input wire logic        cmd_valid_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence took(logic [7:0] c);
    cmd_valid_out && cmd_out[15:8] == c;
  endsequence
  sequence ready_with(logic [15:0] w);
    response_out[10] && data_out == w;
  endsequence
  proto_word_a: assert property (
    took(CMD_READ_PROTOCOL) |-> ##[1:4] ready_with(PROTOCOL_WORD))
    else $error("protocol word not offered");
  ctrl_word_a: assert property (
    took(CMD_CTRL_RESPONSE) |-> ##[1:4] ready_with(16'hffff))
    else $error("control response word not offered");
  lock_set_a: assert property (
    took(CMD_SET_LOCK) |-> ##[1:4] !response_out[7])
    else $error("lock bit did not show locked");
  lock_clear_a: assert property (
    took(CMD_CLEAR_LOCK) |-> ##[1:4] response_out[7])
    else $error("lock bit did not show unlocked");
  write_busy_a: assert property (
    data_wr_in && response_out[9] |-> ##[1:2] !response_out[9])
    else $error("write ready stayed up after a command");
  read_drop_a: assert property (
    data_rd_in && response_out[10] |-> ##[1:3] !response_out[10])
    else $error("read ready stayed up after the read");
  fixed_bits_a: assert property (
    !$past(rst_in) |-> response_out[6:0] == RESP_LOW_FILL
      && response_out[15:11] == 5'b01111)
    else $error("fixed response bits wrong");
  fhs_show_a: assert property (
    fhs_capable_in [*6] |-> !response_out[8])
    else $error("fast handshake not reported");
  event_pulse_a: assert property (
    request_true_out |=> !request_true_out)
    else $error("request true held longer than one cycle");
endmodule
bind wssr_top wssr_asserts chk (.clk_in(clk_in), .rst_in(rst_in),
  .data_wr_in(data_wr_in), .data_in(data_in), .data_rd_in(data_rd_in),
  .error_in(error_in), .fhs_capable_in(fhs_capable_in),
  .response_out(response_out), .data_out(data_out),
  .request_true_out(request_true_out), .cmd_out(cmd_out),
  .cmd_valid_out(cmd_valid_out));

// *** wssr_cmdr_model.sv ***
// commander model writing commands and reading replies
`timescale 1ns/1ps
module wssr_cmdr_model
(
  input  wire logic        clk_in,
  input  wire logic [15:0] response_in,
  input  wire logic [15:0] rd_data_in,
  output logic             data_wr_out,
  output logic             data_rd_out,
  output logic [15:0]      data_out
);
  initial
  begin
    data_wr_out = 1'b0;
    data_rd_out = 1'b0;
    data_out    = 16'hffff;
  end
  task automatic await(int b, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++)
    begin
      @(negedge clk_in);
      ok = response_in[b];
    end
  endtask
  task automatic send(logic [15:0] w, output logic ok);
    repeat (2) @(negedge clk_in);
    await(9, ok);
    @(posedge clk_in);
    data_wr_out <= ok;
    data_out    <= w;
    @(posedge clk_in);
    data_wr_out <= 1'b0;
    data_out    <= ~w;
  endtask
  task automatic fetch(output logic [15:0] r, output logic ok);
    repeat (2) @(negedge clk_in);
    await(10, ok);
    @(posedge clk_in);
    data_rd_out <= ok;
    @(posedge clk_in);
    r = rd_data_in;
    data_rd_out <= 1'b0;
  endtask
endmodule

// *** wssr_pkg.sv ***
// package of constants for the word serial servant responder
package wssr_pkg;

  // ---------------------------------------------------------------
  // response register bit positions
  // ---------------------------------------------------------------
  localparam int RESP_READ_READY_BIT  = 10;
  localparam int RESP_WRITE_READY_BIT = 9;
  localparam int RESP_FHS_BIT         = 8;
  localparam int RESP_LOCK_BIT        = 7;
  localparam logic [6:0] RESP_LOW_FILL = 7'h7f;
  localparam logic [4:0] RESP_HIGH_FIXED = 5'h0f;
  localparam logic [15:0] RESP_RESET_WORD = 16'h0000;
  localparam logic [15:0] CMD_RESET_WORD  = 16'h0000;

  // ---------------------------------------------------------------
  // word serial command codes (upper byte selects the command)
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_PROTOCOL = 8'hdf;
  localparam logic [7:0] CMD_STATUS_QUERY  = 8'hcf;
  localparam logic [7:0] CMD_ASYNC_MODE    = 8'ha8;
  localparam logic [7:0] CMD_CTRL_RESPONSE = 8'ha9;
  localparam logic [7:0] CMD_SET_LOCK      = 8'ha4;
  localparam logic [7:0] CMD_CLEAR_LOCK    = 8'ha5;
  localparam logic [7:0] CMD_IRQ_ENABLE    = 8'hbd;
  localparam logic [7:0] CMD_BYTE_REQUEST  = 8'hde;

  // ---------------------------------------------------------------
  // readback words and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] PROTOCOL_WORD    = 16'hfe6b;
  localparam logic [7:0]  STB_UPPER        = 8'hff;
  localparam int          STB_RQS_BIT      = 6;
  localparam logic [3:0]  ASYNC_OK         = 4'hf;
  localparam logic [3:0]  ASYNC_FAIL       = 4'h7;
  localparam logic [7:0]  ASYNC_FILL       = 8'hff;
  localparam logic [15:0] CTRL_RESP_WORD   = 16'hffff;
  localparam logic [15:0] IDLE_READ_WORD   = 16'hffff;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int EXEC_CYCLES = 2;

  typedef enum logic [1:0] {
    WSSR_IDLE  = 2'b00,
    WSSR_EXEC  = 2'b01,
    WSSR_REPLY = 2'b10
  } wssr_state_t;

endpackage

// *** wssr_pulse_sync.sv ***
// two-flop synchroniser with rising-edge pulse output
`timescale 1ns/1ps
module wssr_pulse_sync
  import wssr_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic level_in,
  output logic      level_out,
  output logic      rise_out
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= level_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign level_out = sync_q;
  assign rise_out  = sync_q & ~last_q;
endmodule

// *** wssr_reply_gen.sv ***
// forms the readback word for a decoded query command
`timescale 1ns/1ps
module wssr_reply_gen
  import wssr_pkg::*;
(
  input  wire logic [15:0] cmd_in,
  input  wire logic        rqs_in,
  output logic [15:0]      reply_out,
  output logic             has_reply_out
);
  logic [7:0]  op;
  logic        async_bad;
  logic [15:0] stb_word;
  logic [15:0] async_word;

  assign op        = cmd_in[15:8];
  assign async_bad = cmd_in[0] | cmd_in[1];
  assign stb_word  = {STB_UPPER, 1'b0, rqs_in, 6'h00};
  assign async_word = async_bad
    ? {ASYNC_FAIL, ASYNC_FILL, cmd_in[3:2], 2'b00}
    : {ASYNC_OK, ASYNC_FILL, cmd_in[3:2], 2'b00};

  always_comb
  begin
    reply_out     = IDLE_READ_WORD;
    has_reply_out = 1'b1;
    case (op)
      CMD_READ_PROTOCOL: reply_out = PROTOCOL_WORD;
      CMD_STATUS_QUERY:  reply_out = stb_word;
      CMD_ASYNC_MODE:    reply_out = async_word;
      CMD_CTRL_RESPONSE: reply_out = CTRL_RESP_WORD;
      CMD_BYTE_REQUEST:  reply_out = IDLE_READ_WORD;
      default:           has_reply_out = 1'b0;
    endcase
  end
endmodule

// *** wssr_top.sv ***
// word serial servant responder: response register and command decode
// How it works
// - read ready set on readback, cleared after read
// - write ready only while a command fits
// - bit 8 shows fast handshake availability
// - bit 7 follows set and clear lock
// - no high data register exists
// - each low data write taken while write ready is set decoded as command
// - read protocol query returns capability word
// - capability upper bits fixed per layout
// - capability bits 6,5 one, bit 4 zero
// - capability bits 3,1,0 one, bit 2 zero
// - status byte reply, service flag cleared
// - async mode fails when bit 0/1 set
// - async reply echoes bits 3 and 2
// - control response reply all ones
// - request true only after interrupt enable
`timescale 1ns/1ps
module wssr_top
  import wssr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        data_wr_in,
  input  wire logic [15:0] data_in,
  input  wire logic        data_rd_in,
  input  wire logic        error_in,
  input  wire logic        fhs_capable_in,
  output logic [15:0]      response_out,
  output logic [15:0]      data_out,
  output logic             request_true_out,
  output logic [15:0]      cmd_out,
  output logic             cmd_valid_out
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic err_rise;
  logic fhs_level;

  wssr_pulse_sync u_err_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .level_in  (error_in),
    .level_out (),
    .rise_out  (err_rise)
  );

  wssr_pulse_sync u_fhs_sync (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    .level_in  (fhs_capable_in),
    .level_out (fhs_level),
    .rise_out  ()
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wssr_state_t  state_q;
  wssr_state_t  state_d;
  logic [15:0]  cmd_q;
  logic [15:0]  reply_q;
  logic         read_ready_q;
  logic         write_ready_q;
  logic         lock_q;
  logic         irq_en_q;
  logic         rqs_q;
  logic         fhs_q;
  logic         req_true_q;
  logic         cmd_valid_q;
  logic [1:0]   exec_cnt_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic [15:0] reply_w;
  logic        has_reply_w;
  logic        wr_take;
  logic        exec_done;
  logic        is_set_lock;
  logic        is_clr_lock;
  logic        is_irq_en;
  logic        is_stb;
  logic        rd_take;
  logic        req_fire;
  logic        in_exec;

  wssr_reply_gen u_reply (
    .cmd_in        (cmd_q),
    .rqs_in        (rqs_q),
    .reply_out     (reply_w),
    .has_reply_out (has_reply_w)
  );

  assign wr_take     = data_wr_in & write_ready_q;
  assign in_exec     = state_q == WSSR_EXEC;
  assign exec_done   = in_exec &&
                       (exec_cnt_q == 2'(EXEC_CYCLES - 1));
  assign is_set_lock = cmd_q[15:8] == CMD_SET_LOCK;
  assign is_clr_lock = cmd_q[15:8] == CMD_CLEAR_LOCK;
  assign is_irq_en   = cmd_q[15:8] == CMD_IRQ_ENABLE;
  assign is_stb      = cmd_q[15:8] == CMD_STATUS_QUERY;
  assign rd_take     = data_rd_in & read_ready_q;
  assign req_fire    = err_rise & irq_en_q;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      WSSR_IDLE:
      begin
        if (wr_take)
          state_d = WSSR_EXEC;
      end
      WSSR_EXEC:
      begin
        if (exec_done && has_reply_w)
          state_d = WSSR_REPLY;
        else if (exec_done)
          state_d = WSSR_IDLE;
      end
      WSSR_REPLY:
      begin
        if (rd_take)
          state_d = WSSR_IDLE;
      end
      default:
      begin
        state_d = WSSR_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      state_q <= WSSR_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cmd_valid_q <= 1'b0;
    else
      cmd_valid_q <= wr_take;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cmd_q <= CMD_RESET_WORD;
    else if (wr_take)
      cmd_q <= data_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      exec_cnt_q <= 2'h0;
    else if (in_exec)
      exec_cnt_q <= exec_cnt_q + 2'h1;
    else
      exec_cnt_q <= 2'h0;
  end

  // ---------------------------------------------------------------
  // handshake bits and reply
  // ---------------------------------------------------------------
  logic rr_set;
  logic wr_clr;
  logic wr_set;
  logic lock_set;
  logic lock_clr;
  logic irq_load;
  logic rqs_clr;

  assign rr_set   = exec_done & has_reply_w;
  assign wr_clr   = wr_take;
  assign wr_set   = (state_d == WSSR_IDLE) && (state_q != WSSR_IDLE);
  assign lock_set = exec_done & is_set_lock;
  assign lock_clr = exec_done & is_clr_lock;
  assign irq_load = exec_done & is_irq_en;
  assign rqs_clr  = exec_done & is_stb;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      fhs_q <= 1'b0;
    else
      fhs_q <= fhs_level;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      write_ready_q <= 1'b1;
    else if (wr_clr)
      write_ready_q <= 1'b0;
    else if (wr_set)
      write_ready_q <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      read_ready_q <= 1'b0;
    else if (rr_set)
      read_ready_q <= 1'b1;
    else if (rd_take)
      read_ready_q <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      reply_q <= IDLE_READ_WORD;
    else if (rr_set)
      reply_q <= reply_w;
  end

  // ---------------------------------------------------------------
  // lock, interrupt enable, service request
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      lock_q <= 1'b0;
    else if (lock_set)
      lock_q <= 1'b1;
    else if (lock_clr)
      lock_q <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_en_q <= 1'b0;
    else if (irq_load)
      irq_en_q <= cmd_q[0];
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      req_true_q <= 1'b0;
    else
      req_true_q <= req_fire;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rqs_q <= 1'b0;
    else if (req_fire)
      rqs_q <= 1'b1;
    else if (rqs_clr)
      rqs_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic [15:0] resp_d;
  logic [15:0] resp_q;
  logic [15:0] data_q;

  assign resp_d = {RESP_HIGH_FIXED,
                   read_ready_q,
                   write_ready_q,
                   ~fhs_q,
                   ~lock_q,
                   RESP_LOW_FILL};

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      resp_q <= RESP_RESET_WORD;
    else
      resp_q <= resp_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      data_q <= IDLE_READ_WORD;
    else
      data_q <= reply_q;
  end

  assign response_out     = resp_q;
  assign data_out         = data_q;
  assign request_true_out = req_true_q;
  assign cmd_out          = cmd_q;
  assign cmd_valid_out    = cmd_valid_q;
endmodule
